/* dv/rdsc_top_tb.sv */
// Self-checking testbench of the radio demodulator and synthesizer config bank
`timescale 1ns/100ps
`include "rdsc_cfg.svh"
module rdsc_top_tb;
    import rdsc_pkg::*;
    localparam int LUT_LEN = 9;
    localparam int MAX_CYC = 20000;
    localparam logic [31:0] A_BW = {`RDSC_IDX_POST_BW, 2'b00};
    localparam logic [31:0] A_RSVD = {`RDSC_IDX_RSVD, 2'b00};
    localparam logic [31:0] A_SYN = {`RDSC_IDX_SYNTH, 2'b00};
    localparam logic [31:0] A_GL = {`RDSC_IDX_GLUT, 2'b00};
    localparam logic [31:0] A_NONE = 32'h0000_0450;
    localparam logic [31:0] A_STAT = {`RDSC_IDX_STATUS, 2'b00};

    logic hclk, hresetn, hsel, hwrite, preamble_match, mod_shaped;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] data_rate;
    logic [7:0] pram_addr, pram_rdata, lut_data;
    logic [3:0] lut_idx;
    logic [8:0] code_a_khz;
    logic [1:0] correlator_phase;
    logic hreadyout, hresp, pram_rd, lut_valid, lut_custom;
    logic gain_free_run, gain_manual, gain_hold, gain_sync_lock;
    rdsc_radio_e radio_state;
    int n_mismatch, checked, cyc;
    logic [31:0] rd;

    rdsc_top #(.LUT_LEN(LUT_LEN)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .radio_state(radio_state),
        .preamble_match(preamble_match), .data_rate(data_rate), .mod_shaped(mod_shaped),
        .pram_rd(pram_rd), .pram_addr(pram_addr), .pram_rdata(pram_rdata), .lut_valid(lut_valid),
        .lut_idx(lut_idx), .lut_data(lut_data), .lut_custom(lut_custom),
        .code_a_khz(code_a_khz), .correlator_phase(correlator_phase),
        .gain_free_run(gain_free_run), .gain_manual(gain_manual), .gain_hold(gain_hold),
        .gain_sync_lock(gain_sync_lock));

    // ----------------------------------------
    // Clock, packet RAM stand-in and timeout
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // One-cycle read latency; between reads the data line toggles so stale data never matches
    always @(posedge hclk) begin
        pram_rdata <= !hresetn ? 8'h00 : (pram_rd ? (pram_addr ^ 8'h5a) : ~pram_rdata);
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == MAX_CYC) begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Entered just after a rising edge; signals held until hready is seen high at an edge
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdv);
        logic ok;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= `RDSC_HSIZE_WORD;
        do begin
            @(negedge hclk);
            ok = hreadyout;
            @(posedge hclk);
        end while (ok !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin
            @(negedge hclk);
            ok = hreadyout;
            rdv = hrdata;
            @(posedge hclk);
        end while (ok !== 1'b1);
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [7:0] v);
        logic [31:0] dummy;
        ahb(1'b1, a, {24'h0, v}, dummy);
    endtask

    task automatic rd_check(input string what, input logic [31:0] a, input logic [7:0] exp);
        ahb(1'b0, a, 32'h0, rd);
        cmp(what, {24'h0, exp}, rd);
    endtask

    // Enter a radio state from idle and judge all nine table entries
    task automatic load(input rdsc_radio_e st, input logic [1:0] sel, input logic [5:0] a,
        input logic [3:0] b, input logic wide);
        int k, n;
        logic [7:0] exp;
        radio_state <= idle_state;
        repeat (3) @(posedge hclk);
        radio_state <= st;
        k = 0;
        n = 0;
        while (k < LUT_LEN && n < 40) begin
            @(negedge hclk);
            n = n + 1;
            if (lut_valid === 1'b1) begin
                if (st == transmit_state) begin
                    exp = sel[1] ? ((8'h10 + 8'(k)) ^ 8'h5a) : (wide ? 8'h80 + 8'(4 * k) : 8'h40 + 8'(2 * k));
                    cmp("tx custom", {31'h0, sel[1]}, {31'h0, lut_custom});
                end else if (sel[0] && k < 2) begin
                    exp = (k == 0) ? {a, 2'b00} : {4'h0, b};
                    cmp("rx custom", 32'h1, {31'h0, lut_custom});
                end else begin
                    exp = 8'h10 + 8'(k);
                end
                cmp("lut idx", 32'(k), {28'h0, lut_idx});
                cmp("lut data", {24'h0, exp}, {24'h0, lut_data});
                k = k + 1;
            end
        end
        cmp("entries", 32'(LUT_LEN), 32'(k));
        @(posedge hclk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd_check("bw reset", A_BW, `RDSC_RST_POST_BW);
        rd_check("rsvd reset", A_RSVD, `RDSC_RST_RSVD);
        rd_check("synth reset", A_SYN, `RDSC_RST_SYNTH);
        rd_check("glut reset", A_GL, `RDSC_RST_GLUT);
        wr_reg(A_SYN, 8'ha5);
        wr_reg(A_GL, 8'h5a);
        wr_reg(A_NONE, 8'h77);
        wr_reg(A_RSVD, 8'h00);
        rd_check("synth rb", A_SYN, 8'ha5);
        rd_check("glut rb", A_GL, 8'h5a);
        rd_check("rsvd rb", A_RSVD, 8'h00);
        rd_check("unmapped", A_NONE, 8'h00);
        cmp("hresp", 32'h0, {31'h0, hresp});
        $display("test regs done");
    endtask

    task automatic t_bw();
        // Code 4 gives 8 kHz, four fifths of the default 10 kbps rate
        logic [7:0] v[4] = '{8'h01, 8'h04, 8'h80, 8'hff};
        foreach (v[i]) begin
            wr_reg(A_BW, v[i]);
            @(negedge hclk);
            cmp("bw khz", {23'h0, v[i], 1'b0}, {23'h0, code_a_khz});
            rd_check("bw rb", A_BW, v[i]);
            @(posedge hclk);
        end
        $display("test bandwidth done");
    endtask

    task automatic t_fields();
        for (int g = 0; g < 8; g++) begin
            preamble_match <= g[2];
            wr_reg(A_SYN, {6'h0, g[1:0]});
            wr_reg(A_GL, {g[1:0], 6'h0});
            @(negedge hclk);
            cmp("phase", 32'(g[1:0]), {30'h0, correlator_phase});
            cmp("gain", {28'h0, g[1:0] == 2'd0, g[1:0] == 2'd1, g[1:0] == 2'd2, g[1:0] == 2'd3 && !g[2]},
                {28'h0, gain_free_run, gain_manual, gain_hold, gain_sync_lock});
            @(posedge hclk);
        end
        $display("test fields done");
    endtask

    task automatic t_tables();
        logic [5:0] a;
        logic [3:0] b;
        for (int s = 0; s < 4; s++) begin
            // Config fields stay zero in modes 0 and 2
            a = s[0] ? 6'h2b : 6'h00;
            b = s[0] ? 4'h9 : 4'h0;
            wr_reg(A_SYN, {a, 2'b01});
            wr_reg(A_GL, {2'b00, s[1:0], b});
            load(receive_state, s[1:0], a, b, 1'b0);
            load(transmit_state, s[1:0], a, b, 1'b0);
        end
        // Stand-in RAM is a fixed pattern, so the tx table counts as reloaded on wake
        radio_state <= sleep_state;
        repeat (2) @(posedge hclk);
        load(transmit_state, 2'd3, 6'h2b, 4'h9, 1'b0);
        wr_reg(A_GL, 8'h00);
        data_rate <= 12'h3e8;
        load(transmit_state, 2'd0, 6'h0, 4'h0, 1'b1);
        data_rate <= 12'h064;
        mod_shaped <= 1'b1;
        load(transmit_state, 2'd0, 6'h0, 4'h0, 1'b1);
        mod_shaped <= 1'b0;
        load(receive_state, 2'd0, 6'h0, 4'h0, 1'b0);
        // Twelve loads, loader idle, last entry from ROM, mode 0; the write is dropped
        wr_reg(A_STAT, 8'hff);
        rd_check("status", A_STAT, 8'h0c);
        $display("test tables done");
    endtask

    // ----------------------------------------
    // Closing report
    // ----------------------------------------
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        n_mismatch = 0;
        checked = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        radio_state = idle_state;
        preamble_match = 1'b0;
        data_rate = 12'h064;
        mod_shaped = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_bw();
        t_fields();
        t_tables();
        stop_test();
    end
endmodule // rdsc_top_tb

/* rtl/rdsc_ahb_slave.sv */
// AHB-Lite front end: word writes at zero wait, reads with one wait state
`timescale 1ns/100ps
`include "rdsc_cfg.svh"
module rdsc_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [7:0] rd_data,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic reg_wr,
    output logic [29:0] reg_idx,
    output logic [7:0] reg_wdata
);
    logic ph_q, wr_q, rd_wait_q;
    logic [29:0] idx_q;
    logic [31:0] hrdata_q;
    wire take = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 1'b0;
            wr_q <= 1'b0;
            rd_wait_q <= 1'b0;
            idx_q <= 30'h0;
            hrdata_q <= 32'h0;
        end else if (rd_wait_q) begin
            // Wait state lets a write in the previous data phase land first
            rd_wait_q <= 1'b0;
            hrdata_q <= {24'h0, rd_data};
        end else if (take) begin
            ph_q <= 1'b1;
            wr_q <= hwrite && (hsize == `RDSC_HSIZE_WORD);
            rd_wait_q <= !hwrite;
            idx_q <= haddr[31:2];
        end else begin
            ph_q <= 1'b0;
        end
    end

    assign hreadyout = !rd_wait_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign reg_wr = ph_q && wr_q;
    assign reg_idx = idx_q;
    assign reg_wdata = hwdata[7:0];
endmodule // rdsc_ahb_slave

/* rtl/rdsc_cfg.svh */
// Offsets, field positions, reset values and table constants of the config bank
`ifndef RDSC_CFG_SVH
`define RDSC_CFG_SVH

`define RDSC_IDX_POST_BW 30'h110
`define RDSC_IDX_RSVD 30'h111
`define RDSC_IDX_SYNTH 30'h112
`define RDSC_IDX_GLUT 30'h113
`define RDSC_IDX_STATUS 30'h140

`define RDSC_RST_POST_BW 8'h01
`define RDSC_RST_RSVD 8'h00
`define RDSC_RST_SYNTH 8'h00
`define RDSC_RST_GLUT 8'h00

`define RDSC_F_CFG_A 7:2
`define RDSC_F_PHASE 1:0
`define RDSC_F_GAIN 7:6
`define RDSC_F_TSEL 5:4
`define RDSC_F_CFG_B 3:0

`define RDSC_BW_SCALE 9'h2
`define RDSC_HSIZE_WORD 3'h2
`define RDSC_PRAM_TX_BASE 8'h10
`define RDSC_LUT_LEN 9
`define RDSC_FAST_RATE 12'h3e8
`define RDSC_ROM_RX_BASE 8'h10
`define RDSC_ROM_TX_BASE 8'h40
`define RDSC_ROM_TXW_BASE 8'h80

`endif

/* rtl/rdsc_lut_loader.sv */
// Loop-bandwidth table loader run on each entry into transmit or receive
`timescale 1ns/100ps
`include "rdsc_cfg.svh"
module rdsc_lut_loader #(
    parameter int unsigned LUT_LEN = `RDSC_LUT_LEN
) (
    input wire logic hclk,
    input wire logic hresetn,
    input rdsc_pkg::rdsc_radio_e radio_state,
    input wire logic [1:0] table_sel,
    input wire logic [5:0] rx_cfg_a,
    input wire logic [3:0] rx_cfg_b,
    input wire logic tx_wide,
    output logic pram_rd,
    output logic [7:0] pram_addr,
    input wire logic [7:0] pram_rdata,
    output logic lut_valid,
    output logic [3:0] lut_idx,
    output logic [7:0] lut_data,
    output logic lut_custom,
    output logic busy,
    output logic done
);
    import rdsc_pkg::*;

    function automatic logic [7:0] rom_word(input logic [1:0] bank, input logic [3:0] idx);
        case (bank)
            2'h1: rom_word = `RDSC_ROM_TX_BASE + {3'h0, idx, 1'h0};
            2'h2: rom_word = `RDSC_ROM_TXW_BASE + {2'h0, idx, 2'h0};
            default: rom_word = `RDSC_ROM_RX_BASE + {4'h0, idx};
        endcase
    endfunction

    rdsc_ld_e st_q;
    rdsc_radio_e prev_q;
    logic ram_q, cus_q, s1_v_q, s1_ram_q, s1_cus_q;
    logic [1:0] bank_q, s1_bank_q;
    logic [3:0] cnt_q, s1_idx_q;
    logic lut_valid_q, lut_custom_q;
    logic [3:0] lut_idx_q;
    logic [7:0] lut_data_q;

    wire enter_tx = (radio_state == transmit_state) && (prev_q != transmit_state);
    wire enter_rx = (radio_state == receive_state) && (prev_q != receive_state);
    wire start = enter_tx || enter_rx;
    wire issue = (st_q == ld_run);
    wire last = (cnt_q == 4'(LUT_LEN - 1));
    wire use_ram = enter_tx && rdsc_tx_custom(table_sel);
    wire use_cus = enter_rx && rdsc_rx_custom(table_sel);
    // Receive is always the narrow bank; transmit picks by rate and shaping
    wire [1:0] bank = enter_tx ? (tx_wide ? 2'h2 : 2'h1) : 2'h0;
    wire [7:0] cus_word = (s1_idx_q == 4'h0) ? {rx_cfg_a, 2'h0} :
                          (s1_idx_q == 4'h1) ? {4'h0, rx_cfg_b} : rom_word(2'h0, s1_idx_q);
    wire [7:0] word = s1_ram_q ? pram_rdata : (s1_cus_q ? cus_word : rom_word(s1_bank_q, s1_idx_q));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ld_idle;
            prev_q <= idle_state;
            cnt_q <= 4'h0;
            ram_q <= 1'b0;
            cus_q <= 1'b0;
            bank_q <= 2'h0;
        end else begin
            prev_q <= radio_state;
            if (start) begin
                // A fresh entry restarts the load from the first entry
                st_q <= ld_run;
                cnt_q <= 4'h0;
                ram_q <= use_ram;
                cus_q <= use_ram || use_cus;
                bank_q <= bank;
            end else if (issue && last) begin
                st_q <= ld_idle;
            end else if (issue) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_v_q <= 1'b0;
            s1_ram_q <= 1'b0;
            s1_cus_q <= 1'b0;
            s1_bank_q <= 2'h0;
            s1_idx_q <= 4'h0;
            lut_valid_q <= 1'b0;
            lut_idx_q <= 4'h0;
            lut_data_q <= 8'h0;
            lut_custom_q <= 1'b0;
        end else begin
            s1_v_q <= issue;
            s1_ram_q <= ram_q;
            s1_cus_q <= cus_q;
            s1_bank_q <= bank_q;
            s1_idx_q <= cnt_q;
            lut_valid_q <= s1_v_q;
            lut_idx_q <= s1_idx_q;
            lut_data_q <= word;
            lut_custom_q <= s1_cus_q;
        end
    end

    assign pram_rd = issue && ram_q;
    assign pram_addr = `RDSC_PRAM_TX_BASE + {4'h0, cnt_q};
    assign lut_valid = lut_valid_q;
    assign lut_idx = lut_idx_q;
    assign lut_data = lut_data_q;
    assign lut_custom = lut_custom_q;
    assign busy = issue || s1_v_q || lut_valid_q;
    assign done = lut_valid_q && (lut_idx_q == 4'(LUT_LEN - 1));
endmodule // rdsc_lut_loader

/* rtl/rdsc_pkg.sv */
// Types and table-select decoding shared by the config bank
package rdsc_pkg;
    typedef enum logic [1:0] {idle_state, sleep_state, receive_state, transmit_state} rdsc_radio_e;
    typedef enum logic [1:0] {gain_free, gain_manual, gain_hold, gain_sync} rdsc_gain_e;
    typedef enum logic {ld_idle, ld_run} rdsc_ld_e;

    function automatic logic rdsc_tx_custom(input logic [1:0] sel);
        rdsc_tx_custom = sel[1];
    endfunction

    function automatic logic rdsc_rx_custom(input logic [1:0] sel);
        rdsc_rx_custom = sel[0];
    endfunction
endpackage

/* rtl/rdsc_top.sv */
// Radio demodulator and synthesizer configuration bank on AHB-Lite
`timescale 1ns/100ps
`include "rdsc_cfg.svh"

// Function
// - Post-demodulator filter bandwidth in kHz is twice the programmed code.
// - Low two bits of synth register set correlator demodulator phase.
// - Gain field: free run, manual, hold, sync lock when preamble match zero.
// - Mode 0: load ROM tables on every entry into transmit or receive.
// - Mode 1: custom receive table, entries 0 and 1 from config fields, ROM for transmit.
// - Mode 2: transmit table from packet RAM 0x10 to 0x18, ROM receive.
// - Mode 3: custom receive table and packet RAM transmit table.
// - Automatic tables: narrow receive, transmit chosen by rate and modulation.
module rdsc_top #(
    parameter int unsigned LUT_LEN = `RDSC_LUT_LEN
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input rdsc_pkg::rdsc_radio_e radio_state,
    input wire logic preamble_match,
    input wire logic [11:0] data_rate,
    input wire logic mod_shaped,
    output logic pram_rd,
    output logic [7:0] pram_addr,
    input wire logic [7:0] pram_rdata,
    output logic lut_valid,
    output logic [3:0] lut_idx,
    output logic [7:0] lut_data,
    output logic lut_custom,
    output logic [8:0] code_a_khz,
    output logic [1:0] correlator_phase,
    output logic gain_free_run,
    output logic gain_manual,
    output logic gain_hold,
    output logic gain_sync_lock
);
    import rdsc_pkg::*;

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    logic reg_wr;
    logic [29:0] reg_idx;
    logic [7:0] reg_wdata;
    logic [7:0] rd_data;

    rdsc_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .rd_data(rd_data),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .reg_wr(reg_wr),
        .reg_idx(reg_idx),
        .reg_wdata(reg_wdata)
    );

    // ------------------------------------------------------------
    // Config registers
    // ------------------------------------------------------------
    logic [7:0] post_bw_q, rsvd_q, synth_q, glut_q;
    logic [3:0] loads_q;
    wire hit_post_bw = (reg_idx == `RDSC_IDX_POST_BW);
    wire hit_rsvd = (reg_idx == `RDSC_IDX_RSVD);
    wire hit_synth = (reg_idx == `RDSC_IDX_SYNTH);
    wire hit_glut = (reg_idx == `RDSC_IDX_GLUT);
    wire hit_status = (reg_idx == `RDSC_IDX_STATUS);

    // Plain storage: no check on the host's legal-value obligations
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            post_bw_q <= `RDSC_RST_POST_BW;
            rsvd_q <= `RDSC_RST_RSVD;
            synth_q <= `RDSC_RST_SYNTH;
            glut_q <= `RDSC_RST_GLUT;
        end else if (reg_wr) begin
            if (hit_post_bw) post_bw_q <= reg_wdata;
            if (hit_rsvd) rsvd_q <= reg_wdata;
            if (hit_synth) synth_q <= reg_wdata;
            if (hit_glut) glut_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Table loader
    // ------------------------------------------------------------
    logic ld_busy, ld_done;
    wire [1:0] table_sel = glut_q[`RDSC_F_TSEL];
    wire tx_wide = (data_rate >= `RDSC_FAST_RATE) || mod_shaped;

    rdsc_lut_loader #(
        .LUT_LEN(LUT_LEN)
    ) u_loader (
        .hclk(hclk),
        .hresetn(hresetn),
        .radio_state(radio_state),
        .table_sel(table_sel),
        .rx_cfg_a(synth_q[`RDSC_F_CFG_A]),
        .rx_cfg_b(glut_q[`RDSC_F_CFG_B]),
        .tx_wide(tx_wide),
        .pram_rd(pram_rd),
        .pram_addr(pram_addr),
        .pram_rdata(pram_rdata),
        .lut_valid(lut_valid),
        .lut_idx(lut_idx),
        .lut_data(lut_data),
        .lut_custom(lut_custom),
        .busy(ld_busy),
        .done(ld_done)
    );

    // Wraps; only a rough activity indicator for software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loads_q <= 4'h0;
        end else if (ld_done) begin
            loads_q <= loads_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Read mux and derived outputs
    // ------------------------------------------------------------
    wire [7:0] status = {ld_busy, lut_custom, table_sel, loads_q};
    assign rd_data = hit_post_bw ? post_bw_q :
                     hit_rsvd ? rsvd_q :
                     hit_synth ? synth_q :
                     hit_glut ? glut_q :
                     hit_status ? status : 8'h00;

    wire rdsc_gain_e gain_sel = rdsc_gain_e'(glut_q[`RDSC_F_GAIN]);
    assign code_a_khz = {1'b0, post_bw_q} * `RDSC_BW_SCALE;
    assign correlator_phase = synth_q[`RDSC_F_PHASE];
    assign gain_free_run = (gain_sel == gain_free);
    // Scoped: the output ports shadow the imported literals of the same name
    assign gain_manual = (gain_sel == rdsc_pkg::gain_manual);
    assign gain_hold = (gain_sel == rdsc_pkg::gain_hold);
    assign gain_sync_lock = (gain_sel == gain_sync) && !preamble_match;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    rdsc_radio_e chk_prev_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chk_prev_q <= idle_state;
        end else begin
            chk_prev_q <= radio_state;
        end
    end
    wire chk_ent_tx = (radio_state == transmit_state) && (chk_prev_q != transmit_state);
    wire chk_ent_rx = (radio_state == receive_state) && (chk_prev_q != receive_state);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_bw_scale;
        reg_wr && hit_post_bw |=> code_a_khz == {$past(reg_wdata), 1'b0};
    endproperty
    a_bw_scale: assert property (p_bw_scale) else $error("bandwidth not twice code");

    property p_phase;
        reg_wr && hit_synth |=> correlator_phase == $past(reg_wdata[1:0]);
    endproperty
    a_phase: assert property (p_phase) else $error("correlator phase wrong");

    property p_gain;
        (glut_q[7:6] == 2'h3) |-> (gain_sync_lock == !preamble_match) && !gain_hold && !gain_free_run;
    endproperty
    a_gain: assert property (p_gain) else $error("gain lock decode wrong");

    property p_rom_load;
        (chk_ent_tx || chk_ent_rx) && (table_sel == 2'h0) ##1 !(chk_ent_tx || chk_ent_rx) [*2]
            |=> lut_valid && !lut_custom && (lut_idx == 4'h0);
    endproperty
    a_rom_load: assert property (p_rom_load) else $error("ROM table not loaded");

    property p_rx_custom;
        chk_ent_rx && (table_sel == 2'h1) && $stable(synth_q) ##1 !chk_ent_tx [*2]
            |=> lut_custom && (lut_data == {$past(synth_q[7:2]), 2'h0});
    endproperty
    a_rx_custom: assert property (p_rx_custom) else $error("custom rx table wrong");

    property p_tx_ram;
        chk_ent_tx && (table_sel == 2'h2) |=> pram_rd && (pram_addr == 8'h10);
    endproperty
    a_tx_ram: assert property (p_tx_ram) else $error("tx table not read from RAM");

    property p_tx_ram_end;
        chk_ent_tx && (table_sel == 2'h3) ##1 !(chk_ent_tx || chk_ent_rx) [*8]
            |=> pram_rd && (pram_addr == 8'h18) ##1 !pram_rd;
    endproperty
    a_tx_ram_end: assert property (p_tx_ram_end) else $error("tx table RAM range wrong");

    property p_rx_narrow;
        chk_ent_rx && (table_sel == 2'h0) ##1 !(chk_ent_tx || chk_ent_rx) [*2]
            |=> lut_data == `RDSC_ROM_RX_BASE;
    endproperty
    a_rx_narrow: assert property (p_rx_narrow) else $error("rx table not narrow");

    property p_readback;
        !hreadyout |=> hreadyout && (hrdata == {24'h0, $past(rd_data)});
    endproperty
    a_readback: assert property (p_readback) else $error("read data mismatch");

    property p_no_ram_rx;
        chk_ent_rx ##1 !(chk_ent_tx || chk_ent_rx) [*4] |-> !pram_rd;
    endproperty
    a_no_ram_rx: assert property (p_no_ram_rx) else $error("rx load read packet RAM");

    property p_post_store;
        reg_wr && hit_post_bw |=> post_bw_q == $past(reg_wdata);
    endproperty
    a_post_store: assert property (p_post_store) else $error("bandwidth byte not stored");

    property p_rsvd_store;
        reg_wr && hit_rsvd |=> rsvd_q == $past(reg_wdata);
    endproperty
    a_rsvd_store: assert property (p_rsvd_store) else $error("reserved byte not stored");

    property p_synth_store;
        reg_wr && hit_synth |=> synth_q == $past(reg_wdata);
    endproperty
    a_synth_store: assert property (p_synth_store) else $error("synth byte not stored");

    property p_glut_store;
        reg_wr && hit_glut |=> glut_q == $past(reg_wdata);
    endproperty
    a_glut_store: assert property (p_glut_store) else $error("gain byte not stored");

    property p_gain_free;
        (glut_q[7:6] == 2'h0) |-> gain_free_run && !gain_manual && !gain_hold && !gain_sync_lock;
    endproperty
    a_gain_free: assert property (p_gain_free) else $error("free run decode wrong");

    property p_gain_manual;
        (glut_q[7:6] == 2'h1) |-> gain_manual && !gain_free_run && !gain_hold && !gain_sync_lock;
    endproperty
    a_gain_manual: assert property (p_gain_manual) else $error("manual decode wrong");

    property p_gain_hold;
        (glut_q[7:6] == 2'h2) |-> gain_hold && !gain_free_run && !gain_manual && !gain_sync_lock;
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("hold decode wrong");

    property p_tx_rom_m1;
        chk_ent_tx && (table_sel == 2'h1) ##1 !(chk_ent_tx || chk_ent_rx) [*2]
            |=> lut_valid && !lut_custom && !pram_rd;
    endproperty
    a_tx_rom_m1: assert property (p_tx_rom_m1) else $error("mode 1 tx not from ROM");

    property p_rx_rom_m2;
        chk_ent_rx && (table_sel == 2'h2) ##1 !(chk_ent_tx || chk_ent_rx) [*2]
            |=> lut_valid && !lut_custom && (lut_data == `RDSC_ROM_RX_BASE);
    endproperty
    a_rx_rom_m2: assert property (p_rx_rom_m2) else $error("mode 2 rx not from ROM");

    property p_tx_ram_m3;
        chk_ent_tx && (table_sel == 2'h3) |=> pram_rd && (pram_addr == 8'h10);
    endproperty
    a_tx_ram_m3: assert property (p_tx_ram_m3) else $error("mode 3 tx not from RAM");

    property p_rx_cus_m3;
        chk_ent_rx && (table_sel == 2'h3) ##1 !(chk_ent_tx || chk_ent_rx) [*2]
            |=> lut_custom && (lut_data == {$past(synth_q[7:2]), 2'h0});
    endproperty
    a_rx_cus_m3: assert property (p_rx_cus_m3) else $error("mode 3 rx not custom");

    property p_tx_narrow;
        chk_ent_tx && (table_sel == 2'h0) && !tx_wide ##1 !(chk_ent_tx || chk_ent_rx) [*2]
            |=> lut_data == `RDSC_ROM_TX_BASE;
    endproperty
    a_tx_narrow: assert property (p_tx_narrow) else $error("tx narrow bank wrong");

    property p_tx_wide;
        chk_ent_tx && (table_sel == 2'h0) && tx_wide ##1 !(chk_ent_tx || chk_ent_rx) [*2]
            |=> lut_data == `RDSC_ROM_TXW_BASE;
    endproperty
    a_tx_wide: assert property (p_tx_wide) else $error("tx wide bank wrong");
endmodule // rdsc_top
